/* File: smv_cfg.svh */
// Constants for the bus-programmed voltage-code block
`ifndef SMV_CFG_SVH
`define SMV_CFG_SVH
`define SMV_SLAVE_ADDR     7'h71
`define SMV_CMD_ON         3'h0
`define SMV_CMD_SETUP      3'h1
`define SMV_CMD_READBACK   3'h2
`define SMV_CMD_OFF        3'h3
`define SMV_CODE_RESET     5'h1f
`define SMV_CODE_MSB       7
`define SMV_CODE_LSB       3
`define SMV_CLK_PERIOD_NS  10
`define SMV_SETTLE_NS      50000
`define SMV_SETTLE_CYCLES  ((`SMV_SETTLE_NS + `SMV_CLK_PERIOD_NS - 1) / `SMV_CLK_PERIOD_NS)
`endif

/* File: smv_host_model.sv */
// Bus master model that drives frames at the serial link
`timescale 1ns/1ps
`include "smv_cfg.svh"
module smv_host_model (
  // Bus wires
  output logic      sclOut,
  output logic      sdaLow,
  input  wire logic sdaWire
);
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  // One bit; the clock stands high between frames
  task automatic bitX(input logic b, output logic r);
    #30 sdaLow = ~b;
    #32 sclOut = 1'b1;
    r = sdaWire;
    #63 sclOut = 1'b0;
  endtask : bitX
  task automatic start;
    #30 sdaLow = 1'b0;
    #32 sclOut = 1'b1;
    #125 sdaLow = 1'b1;
    #125 sclOut = 1'b0;
  endtask : start
  // Stop plus the idle gap between transactions
  task automatic stop;
    #30 sdaLow = 1'b1;
    #32 sclOut = 1'b1;
    #125 sdaLow = 1'b0;
    #1000;
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitX(d[i], q[i]);
    bitX(nine, r);
    ack = ~r;
  endtask : xfer
  task automatic writeWord(input logic [6:0] a, input logic [7:0] c, lo, hi, output logic ack);
    logic [7:0] q;
    logic       k;
    start();
    xfer({a, 1'b0}, 1'b1, q, ack);
    xfer(c, 1'b1, q, k);
    xfer(lo, 1'b1, q, k);
    xfer(hi, 1'b1, q, k);
    stop();
  endtask : writeWord
  task automatic readWord(output logic [15:0] w);
    logic [7:0] q;
    logic       k;
    start();
    xfer({`SMV_SLAVE_ADDR, 1'b0}, 1'b1, q, k);
    xfer({`SMV_CMD_READBACK, 5'h00}, 1'b1, q, k);
    start();
    xfer({`SMV_SLAVE_ADDR, 1'b1}, 1'b1, q, k);
    xfer(8'hff, 1'b0, w[15:8], k);
    xfer(8'hff, 1'b1, w[7:0], k);
    stop();
  endtask : readWord
endmodule : smv_host_model

/* File: smv_pkg.sv */
// Types for the bus-programmed voltage-code block
package smv_pkg;
  typedef logic [4:0] smv_code_t;
  typedef logic [7:0] smv_byte_t;
  typedef enum logic [1:0] {SMV_ADDR_BYTE, SMV_CMD_BYTE, SMV_DATA_LO, SMV_DATA_HI} smv_phase_t;
endpackage : smv_pkg

/* File: smv_programmer.sv */
// Bus slave, on/off sequencer and settle timer for the converter
`timescale 1ns/1ps
`include "smv_cfg.svh"

//  Contract
// - Answer only at fixed slave address
// - Sample on SCL rise, shift on fall
// - Setup, On, Off writes; Read-Back read
// - Setup loads two 5-bit code registers
// - On/Off discard data, codes unchanged
// - Read-Back returns codes, each plus off flag
// - Enable low forces run output low
// - Enable high hands run to sequencer
// - Reset holds converter in shutdown
// - On ignored until one Setup done
// - Two adjacent On commands turn on
// - Two adjacent Off commands turn off
// - Bus-on state set/cleared by pairs, else holds
// - Codes locked while bus-on and enable high
// - Off flag low only when converter on
// - Run released when on, driven low otherwise
// - Settle output low when off, 50us pulses
// - Select low picks code zero, high one
// - Command top bits give transaction type
// - Reset idles bus, codes to all ones
module smv_programmer
  import smv_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = `SMV_SETTLE_CYCLES
) (
  // Core clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // Serial bus
  input  wire logic      scl,
  input  wire logic      sdaIn,
  output logic           sdaOut,
  output logic           sdaOe,
  // Control pins
  input  wire logic      globalEnableIn,
  input  wire logic      settingSelectIn,
  // Converter pins
  output logic           converterRunOut,
  output logic           converterRunOe,
  output logic           settleTimerOut,
  output logic           settleTimerOe,
  output smv_code_t      activeCode
);

  // Link side, clocked by scl
  logic       [3:0]  bitCnt_q;
  smv_phase_t        phase_q;
  smv_phase_t        phaseNext;
  logic              active_q;
  logic              readMode_q;
  smv_byte_t         shift_q;
  smv_byte_t         lastCmd_q;
  smv_byte_t         dataLo_q;
  smv_byte_t         dataHi_q;
  logic              wrTgl_q;
  logic              rdTgl_q;
  logic       [10:0] rbSync1_q;
  logic       [10:0] rbSync2_q;
  logic              sdaOe_q;
  // Core side
  logic       [5:0]  syncA_q;
  logic       [5:0]  syncB_q;
  logic       [5:0]  syncC_q;
  logic              frameRst_q;
  logic              busOnState_q;
  logic              pendOn_q;
  logic              pendOff_q;
  logic              setupDone_q;
  smv_code_t         voltageCodeZero_q;
  smv_code_t         voltageCodeOne_q;
  logic              converterOffFlag_q;
  logic              runOe_q;
  logic              timerOe_q;
  logic              onPrev_q;
  logic       [12:0] settleCnt_q;
  logic       [12:0] settleCnt_d;
  smv_code_t         activeCode_q;
  logic              zero_q;

  // Start or stop re-arms the link engine
  wire       sclRst_n = rst_n & ~frameRst_q;
  wire smv_byte_t rxByte = {shift_q[6:0], sdaIn};
  wire       byteDone  = (bitCnt_q == 4'h7);
  wire       addrDone  = byteDone && (phase_q == SMV_ADDR_BYTE);
  wire       addrHit   = (rxByte[7:1] == `SMV_SLAVE_ADDR);
  wire       wrActive  = active_q && !readMode_q;
  wire       ackSlot   = (bitCnt_q == 4'h8) && active_q && ((phase_q == SMV_ADDR_BYTE) || !readMode_q);
  wire       txSlot    = active_q && readMode_q && !bitCnt_q[3]
                         && ((phase_q == SMV_CMD_BYTE) || (phase_q == SMV_DATA_LO));
  wire smv_code_t rbCode  = (phase_q == SMV_CMD_BYTE) ? rbSync2_q[5:1] : rbSync2_q[10:6];
  wire smv_byte_t txByte  = {rbCode, rbSync2_q[0], 2'b00};
  wire       txBit     = txByte[3'd7 - bitCnt_q[2:0]];

  always_comb begin
    unique case (phase_q)
      SMV_ADDR_BYTE: phaseNext = SMV_CMD_BYTE;
      SMV_CMD_BYTE:  phaseNext = SMV_DATA_LO;
      SMV_DATA_LO:   phaseNext = SMV_DATA_HI;
      SMV_DATA_HI:   phaseNext = SMV_DATA_HI;
    endcase
  end

  // Bit engine, samples on rising scl
  always_ff @(posedge scl or negedge sclRst_n) begin
    if (!sclRst_n) begin
      bitCnt_q   <= 4'h0;
      phase_q    <= SMV_ADDR_BYTE;
      active_q   <= 1'b0;
      readMode_q <= 1'b0;
      shift_q    <= 8'h00;
    end else if (bitCnt_q == 4'h8) begin
      bitCnt_q <= 4'h0;
      phase_q  <= phaseNext;
    end else begin
      shift_q  <= rxByte;
      bitCnt_q <= bitCnt_q + 4'h1;
      if (addrDone) begin
        active_q   <= addrHit;
        readMode_q <= rxByte[0];
      end
    end
  end

  // Captured bytes survive repeated starts
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      lastCmd_q <= 8'h00;
      dataLo_q  <= 8'h00;
      dataHi_q  <= 8'h00;
      wrTgl_q   <= 1'b0;
      rdTgl_q   <= 1'b0;
    end else if (bitCnt_q != 4'h8) begin
      if (byteDone && wrActive && phase_q == SMV_CMD_BYTE)
        lastCmd_q <= rxByte;
      if (byteDone && wrActive && phase_q == SMV_DATA_LO)
        dataLo_q <= rxByte;
      if (byteDone && wrActive && phase_q == SMV_DATA_HI) begin
        dataHi_q <= rxByte;
        wrTgl_q  <= ~wrTgl_q;
      end
      if (addrDone && addrHit && rxByte[0])
        rdTgl_q <= ~rdTgl_q;
    end
  end

  // Read-back word brought into the link domain
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      rbSync1_q <= {`SMV_CODE_RESET, `SMV_CODE_RESET, 1'b1};
      rbSync2_q <= {`SMV_CODE_RESET, `SMV_CODE_RESET, 1'b1};
    end else begin
      rbSync1_q <= {voltageCodeOne_q, voltageCodeZero_q, converterOffFlag_q};
      rbSync2_q <= rbSync1_q;
    end
  end

  // Data and acknowledge change on falling scl
  always_ff @(negedge scl or negedge sclRst_n) begin
    if (!sclRst_n)
      sdaOe_q <= 1'b0;
    else
      sdaOe_q <= ackSlot || (txSlot && !txBit);
  end

  // Pin and toggle synchronisers, third stage for edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= 6'h00;
      syncB_q <= 6'h00;
      syncC_q <= 6'h00;
    end else begin
      syncA_q <= {rdTgl_q, wrTgl_q, settingSelectIn, globalEnableIn, sdaIn, scl};
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  wire       sclHigh   = syncB_q[0] && syncC_q[0];
  wire       startSeen = sclHigh && syncC_q[1] && !syncB_q[1];
  wire       stopSeen  = sclHigh && !syncC_q[1] && syncB_q[1];
  wire       enSync    = syncB_q[2];
  wire       selSync   = syncB_q[3];
  wire       selToggle = syncB_q[3] ^ syncC_q[3];
  wire       wrEvt     = syncB_q[4] ^ syncC_q[4];
  wire       rdEvt     = syncB_q[5] ^ syncC_q[5];
  wire [2:0] cmdType   = lastCmd_q[7:5];
  wire       isSetup   = wrEvt && (cmdType == `SMV_CMD_SETUP);
  wire       isOn      = wrEvt && (cmdType == `SMV_CMD_ON);
  wire       isOff     = wrEvt && (cmdType == `SMV_CMD_OFF);
  wire       convOn    = busOnState_q && enSync;
  wire       setupLoad = isSetup && !convOn;
  wire       onAccept  = isOn && setupDone_q;
  wire       settleTrig = convOn && (!onPrev_q || selToggle);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      frameRst_q <= 1'b0;
    else
      frameRst_q <= startSeen || stopSeen;
  end

  // Code registers, written only by Setup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      voltageCodeZero_q <= `SMV_CODE_RESET;
      voltageCodeOne_q  <= `SMV_CODE_RESET;
      setupDone_q       <= 1'b0;
    end else if (setupLoad) begin
      voltageCodeZero_q <= dataLo_q[`SMV_CODE_MSB:`SMV_CODE_LSB];
      voltageCodeOne_q  <= dataHi_q[`SMV_CODE_MSB:`SMV_CODE_LSB];
      setupDone_q       <= 1'b1;
    end
  end

  // On/Off pair sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busOnState_q <= 1'b0;
      pendOn_q     <= 1'b0;
      pendOff_q    <= 1'b0;
    end else if (wrEvt || rdEvt) begin
      pendOn_q  <= onAccept && !pendOn_q;
      pendOff_q <= isOff && !pendOff_q;
      if (onAccept && pendOn_q)
        busOnState_q <= 1'b1;
      else if (isOff && pendOff_q)
        busOnState_q <= 1'b0;
    end
  end

  // Settle interval counter
  assign settleCnt_d = settleTrig ? 13'(SETTLE_CYCLES)
                     : ((settleCnt_q != 13'h0000) ? settleCnt_q - 13'h0001 : 13'h0000);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settleCnt_q        <= 13'h0000;
      onPrev_q           <= 1'b0;
      timerOe_q          <= 1'b1;
      runOe_q            <= 1'b1;
      converterOffFlag_q <= 1'b1;
      activeCode_q       <= `SMV_CODE_RESET;
      zero_q             <= 1'b0;
    end else begin
      settleCnt_q        <= convOn ? settleCnt_d : 13'h0000;
      onPrev_q           <= convOn;
      timerOe_q          <= !convOn || (settleCnt_d != 13'h0000);
      runOe_q            <= !convOn;
      converterOffFlag_q <= !convOn;
      activeCode_q       <= selSync ? voltageCodeOne_q : voltageCodeZero_q;
      zero_q             <= 1'b0;
    end
  end

  assign sdaOut          = zero_q;
  assign sdaOe           = sdaOe_q;
  assign converterRunOut = zero_q;
  assign converterRunOe  = runOe_q;
  assign settleTimerOut  = zero_q;
  assign settleTimerOe   = timerOe_q;
  assign activeCode      = activeCode_q;

  property p_enable_low_drives;
    @(posedge clk) disable iff (!rst_n) !enSync |=> converterRunOe;
  endproperty
  a_enable_low_drives: assert property (p_enable_low_drives) else $error("run not driven with enable low");

  property p_on_releases;
    @(posedge clk) disable iff (!rst_n) (busOnState_q && enSync) |=> !converterRunOe && !converterOffFlag_q;
  endproperty
  a_on_releases: assert property (p_on_releases) else $error("run not released when on");

  property p_flag_when_off;
    @(posedge clk) disable iff (!rst_n) !(busOnState_q && enSync) |=> converterOffFlag_q;
  endproperty
  a_flag_when_off: assert property (p_flag_when_off) else $error("off flag low while off");

  property p_settle_pulse;
    @(posedge clk) disable iff (!rst_n) $rose(convOn) |=> settleTimerOe [*8];
  endproperty
  a_settle_pulse: assert property (p_settle_pulse) else $error("settle pulse too short");

  property p_on_needs_setup;
    @(posedge clk) disable iff (!rst_n) (isOn && !setupDone_q && !busOnState_q) |=> !busOnState_q && !pendOn_q;
  endproperty
  a_on_needs_setup: assert property (p_on_needs_setup) else $error("on taken before setup");

  property p_on_pair;
    @(posedge clk) disable iff (!rst_n) (isOn && setupDone_q && pendOn_q) |=> busOnState_q ##1 busOnState_q;
  endproperty
  a_on_pair: assert property (p_on_pair) else $error("second on did not turn on");

  property p_off_pair;
    @(posedge clk) disable iff (!rst_n) (isOff && pendOff_q) |=> !busOnState_q;
  endproperty
  a_off_pair: assert property (p_off_pair) else $error("second off did not turn off");

  property p_codes_locked;
    @(posedge clk) disable iff (!rst_n) (wrEvt && (convOn || !isSetup))
      |=> $stable(voltageCodeZero_q) && $stable(voltageCodeOne_q);
  endproperty
  a_codes_locked: assert property (p_codes_locked) else $error("codes changed without setup");

  property p_read_clears_pair;
    @(posedge clk) disable iff (!rst_n) rdEvt |=> !pendOn_q && !pendOff_q;
  endproperty
  a_read_clears_pair: assert property (p_read_clears_pair) else $error("pending pair kept");

  property p_select_code;
    @(posedge clk) disable iff (!rst_n) selSync && $stable(voltageCodeOne_q) |=> activeCode == $past(voltageCodeOne_q);
  endproperty
  a_select_code: assert property (p_select_code) else $error("wrong active code");

  property p_foreign_addr;
    @(posedge scl) disable iff (!sclRst_n) (addrDone && !addrHit) |=> !active_q;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("answered foreign address");

endmodule : smv_programmer

/* File: smv_programmer_test.sv */
// Self-checking bench for the voltage-code programmer
`timescale 1ns/1ps
`include "smv_cfg.svh"
module smv_programmer_test
  import smv_pkg::*;
;
  logic      clk = 1'b0;
  logic      rst_n = 1'b0;
  logic      globalEnableIn = 1'b1;
  logic      settingSelectIn = 1'b0;
  logic      scl, sdaLow, sdaOut, sdaOe, ack;
  logic      converterRunOut, converterRunOe, settleTimerOut, settleTimerOe;
  smv_code_t activeCode;
  wire       sdaIn = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;
  int        errors = 0;
  int        n_checks = 0;
  always #5 clk = ~clk;
  smv_host_model smv_host_model_inst (.sclOut(scl), .sdaLow(sdaLow), .sdaWire(sdaIn));
  smv_programmer #(.SETTLE_CYCLES(200)) smv_programmer_inst (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .globalEnableIn(globalEnableIn), .settingSelectIn(settingSelectIn),
    .converterRunOut(converterRunOut), .converterRunOe(converterRunOe),
    .settleTimerOut(settleTimerOut), .settleTimerOe(settleTimerOe), .activeCode(activeCode));
  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] c, input logic [7:0] lo, hi);
    smv_host_model_inst.writeWord(`SMV_SLAVE_ADDR, {c, 5'h00}, lo, hi, ack);
    chk(ack, 1'b1);
  endtask : wr
  task automatic rdChk(input smv_code_t c0, c1, input logic f);
    logic [15:0] w;
    smv_host_model_inst.readWord(w);
    chk(w, {c0, f, 2'b00, c1, f, 2'b00});
    @(negedge clk);
  endtask : rdChk
  // Open-drain pins: value stays low, enable carries the state
  task automatic pins(input logic [1:0] exp);
    @(negedge clk);
    chk({converterRunOut, settleTimerOut, converterRunOe, settleTimerOe}, {2'b00, exp});
  endtask : pins
  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  initial begin
    #400000;
    errors++;
    results();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    pins(2'b11);
    chk(activeCode, `SMV_CODE_RESET);
    rdChk(`SMV_CODE_RESET, `SMV_CODE_RESET, 1'b1);
    wr(`SMV_CMD_ON, 8'h00, 8'h00);
    wr(`SMV_CMD_ON, 8'h00, 8'h00);
    pins(2'b11);
    smv_host_model_inst.writeWord(7'h70, 8'h00, 8'h00, 8'h00, ack);
    chk(ack, 1'b0);
    wr(`SMV_CMD_SETUP, 8'h4f, 8'h5f);
    rdChk(5'h09, 5'h0b, 1'b1);
    chk(activeCode, 5'h09);
    @(negedge clk) settingSelectIn = 1'b1;
    repeat (10) @(negedge clk);
    chk(activeCode, 5'h0b);
    settingSelectIn = 1'b0;
    repeat (10) @(negedge clk);
    wr(`SMV_CMD_ON, 8'h00, 8'h00);
    rdChk(5'h09, 5'h0b, 1'b1);
    wr(`SMV_CMD_ON, 8'h00, 8'h00);
    pins(2'b11);
    smv_host_model_inst.writeWord(7'h10, 8'h00, 8'h00, 8'h00, ack);
    chk(ack, 1'b0);
    wr(`SMV_CMD_ON, 8'h00, 8'h00);
    pins(2'b01);
    #1000;
    pins(2'b00);
    rdChk(5'h09, 5'h0b, 1'b0);
    wr(`SMV_CMD_SETUP, 8'h00, 8'h00);
    wr(`SMV_CMD_OFF, 8'hff, 8'hff);
    pins(2'b00);
    rdChk(5'h09, 5'h0b, 1'b0);
    @(negedge clk) settingSelectIn = 1'b1;
    repeat (10) @(negedge clk);
    pins(2'b01);
    repeat (250) @(negedge clk);
    pins(2'b00);
    globalEnableIn = 1'b0;
    repeat (10) @(negedge clk);
    pins(2'b11);
    wr(`SMV_CMD_SETUP, 8'h10, 8'h18);
    rdChk(5'h02, 5'h03, 1'b1);
    @(negedge clk) globalEnableIn = 1'b1;
    repeat (10) @(negedge clk);
    pins(2'b01);
    chk(activeCode, 5'h03);
    wr(`SMV_CMD_OFF, 8'h00, 8'h00);
    wr(`SMV_CMD_OFF, 8'h00, 8'h00);
    pins(2'b11);
    results();
  end
endmodule : smv_programmer_test
